/* File: gdeio_top.sv */
// Purpose: I/O logic of one general-purpose pad with dual-edge transfer
// Assumes: one 250 MHz clock; capture and drive clocks are enable pulses
// Notes:   registers reached over AXI4-Lite; received words pass a FIFO
`timescale 1ns/1ps
`include "gdeio_regs.svh"

// Function
// - receive bit 0 carries the pad input, and in dual-edge mode bit 0 is the rising sample and bit 1 the falling sample.
// - drive bit 0 is the pad output, and in dual-edge mode bit 0 goes out in the rising half and bit 1 in the falling half.
// - with no input register the pad feeds an unregistered bypass that can reach clock, control or reference nets.
// - the drive enable from the core may pass through an optional register chosen by configuration.
// - output data and drive enable registers run on the drive clock.
// - input capture registers run on an independent capture clock.
// - dual-edge mode samples or launches on both edges and moves two bits per cycle to the core.
// - normal dual-edge timing exchanges each bit at its own edge, resync timing exchanges both on the rising edge.
// - in resync input mode the falling sample is held half a cycle so both bits change at the rising edge.
// - a pad that reuses a differential pair refuses dual-edge mode.
// - each register stage picks its edge, paths register independently, and the output register may invert.
module gdeio_top import gdeio_pkg::*; #(
  parameter int DIV_W        = 16,
  parameter int FIFO_DEPTH   = 32,
  parameter bit PAIR_REUSE   = 1'b0
) (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        rst,
  // AXI4-Lite write
  input  wire logic [3:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read
  input  wire logic [3:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // core side
  input  wire logic [1:0]  pad_drive_bits,
  input  wire logic        pad_drive_enable,
  output logic [1:0]       core_receive_bits,
  output logic             core_receive_valid,
  input  wire logic        core_receive_ready,
  // bypass routes
  output logic             bypass_path,
  output logic             global_clock_net,
  output logic             global_control_net,
  output logic             synth_reference_input,
  output logic             camera_link_reference_input,
  // pad
  input  wire logic        pad_in,
  output logic             pad_out,
  output logic             pad_oe
);

  // ========================================================================
  // parameter check
  generate
    if (DIV_W < 2 || DIV_W > 32 || FIFO_DEPTH < 2) begin : g_bad
      $error("gdeio_top: DIV_W must be 2..32 and FIFO_DEPTH >= 2");
    end
  endgenerate

  // ========================================================================
  // register bus
  gdeio_wr_state_t           wr_state;
  gdeio_wr_state_t           next_wr_state;
  gdeio_rd_state_t           rd_state;
  gdeio_rd_state_t           next_rd_state;
  logic                      aw_got;
  logic                      next_aw_got;
  logic                      w_got;
  logic                      next_w_got;
  logic [3:0]                aw_addr;
  logic [3:0]                next_aw_addr;
  logic [31:0]               w_data;
  logic [31:0]               next_w_data;
  logic [3:0]                w_strb;
  logic [3:0]                next_w_strb;
  logic [1:0]                bresp;
  logic [1:0]                next_bresp;
  logic [31:0]               rdata;
  logic [31:0]               next_rdata;
  logic [1:0]                rresp;
  logic [1:0]                next_rresp;
  logic                      do_write;
  logic [31:0]               merged;
  logic [31:0]               status_word;

  // configuration and status
  logic [`GDEIO_CFG_W-1:0]   cfg;
  logic [`GDEIO_CFG_W-1:0]   next_cfg;
  logic [DIV_W-1:0]          half [2];
  logic [DIV_W-1:0]          next_half [2];
  logic                      reject;
  logic                      next_reject;
  logic                      stalled;
  logic                      next_stalled;

  assign s_axi_awready = wr_state == GDEIO_WS_COLLECT && !aw_got;
  assign s_axi_wready  = wr_state == GDEIO_WS_COLLECT && !w_got;
  assign s_axi_bvalid  = wr_state == GDEIO_WS_RESP;
  assign s_axi_bresp   = bresp;
  assign s_axi_arready = rd_state == GDEIO_RS_IDLE;
  assign s_axi_rvalid  = rd_state == GDEIO_RS_DATA;
  assign s_axi_rdata   = rdata;
  assign s_axi_rresp   = rresp;

  always_comb begin
    merged = 32'h0;
    for (int b = 0; b < 4; b++) begin
      merged[b*8 +: 8] = w_data[b*8 +: 8];
    end
  end

  always_comb begin
    next_wr_state = wr_state;
    next_aw_got   = aw_got;
    next_w_got    = w_got;
    next_aw_addr  = aw_addr;
    next_w_data   = w_data;
    next_w_strb   = w_strb;
    next_bresp    = bresp;
    do_write      = 1'b0;
    unique case (wr_state)
      GDEIO_WS_COLLECT: begin
        if (s_axi_awvalid && !aw_got) begin
          next_aw_got  = 1'b1;
          next_aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !w_got) begin
          next_w_got  = 1'b1;
          next_w_data = s_axi_wdata;
          next_w_strb = s_axi_wstrb;
        end
        if (aw_got && w_got) begin
          do_write      = 1'b1;
          next_aw_got   = 1'b0;
          next_w_got    = 1'b0;
          next_wr_state = GDEIO_WS_RESP;
          next_bresp    = (aw_addr[1:0] == 2'h0) ? `GDEIO_RESP_OKAY
                                                 : `GDEIO_RESP_SLVERR;
        end
      end
      GDEIO_WS_RESP: begin
        if (s_axi_bready) begin
          next_wr_state = GDEIO_WS_COLLECT;
        end
      end
    endcase
  end

  always_comb begin
    next_rd_state = rd_state;
    next_rdata    = rdata;
    next_rresp    = rresp;
    unique case (rd_state)
      GDEIO_RS_IDLE: begin
        if (s_axi_arvalid) begin
          next_rd_state = GDEIO_RS_DATA;
          next_rresp    = `GDEIO_RESP_OKAY;
          next_rdata    = 32'h0;
          if (s_axi_araddr[1:0] != 2'h0) begin
            next_rresp = `GDEIO_RESP_SLVERR;
          end else begin
            unique case (s_axi_araddr)
              `GDEIO_CFG_ADDR:    next_rdata = 32'(cfg);
              `GDEIO_CAPDIV_ADDR: next_rdata = 32'(half[0]);
              `GDEIO_DRVDIV_ADDR: next_rdata = 32'(half[1]);
              `GDEIO_STATUS_ADDR: next_rdata = status_word;
              default:            next_rresp = `GDEIO_RESP_SLVERR;
            endcase
          end
        end
      end
      GDEIO_RS_DATA: begin
        if (s_axi_rready) begin
          next_rd_state = GDEIO_RS_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      wr_state <= GDEIO_WS_COLLECT;
      rd_state <= GDEIO_RS_IDLE;
      aw_got   <= 1'b0;
      w_got    <= 1'b0;
      aw_addr  <= 4'h0;
      w_data   <= 32'h0;
      w_strb   <= 4'h0;
      bresp    <= 2'h0;
      rdata    <= 32'h0;
      rresp    <= 2'h0;
    end else begin
      wr_state <= next_wr_state;
      rd_state <= next_rd_state;
      aw_got   <= next_aw_got;
      w_got    <= next_w_got;
      aw_addr  <= next_aw_addr;
      w_data   <= next_w_data;
      w_strb   <= next_w_strb;
      bresp    <= next_bresp;
      rdata    <= next_rdata;
      rresp    <= next_rresp;
    end
  end

  // ========================================================================
  // register writes
  logic cap_block;

  always_comb begin
    next_cfg     = cfg;
    next_half    = half;
    next_reject  = reject;
    next_stalled = stalled;
    if (do_write && w_strb[0] && aw_addr == `GDEIO_STATUS_ADDR) begin
      if (merged[`GDEIO_ST_REJECT]) next_reject = 1'b0;
      if (merged[`GDEIO_ST_STALL])  next_stalled = 1'b0;
    end
    if (do_write && aw_addr == `GDEIO_CFG_ADDR && w_strb[0] && w_strb[1]) begin
      next_cfg = merged[`GDEIO_CFG_W-1:0];
      if (PAIR_REUSE) begin
        next_cfg[`GDEIO_CFG_IN_DUAL]  = 1'b0;
        next_cfg[`GDEIO_CFG_OUT_DUAL] = 1'b0;
        if (merged[`GDEIO_CFG_IN_DUAL] || merged[`GDEIO_CFG_OUT_DUAL]) begin
          next_reject = 1'b1;
        end
      end
    end
    if (do_write && aw_addr == `GDEIO_CAPDIV_ADDR) begin
      next_half[0] = merged[DIV_W-1:0];
    end
    if (do_write && aw_addr == `GDEIO_DRVDIV_ADDR) begin
      next_half[1] = merged[DIV_W-1:0];
    end
    if (cap_block) begin
      next_stalled = 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      cfg     <= `GDEIO_CFG_RST;
      half[0] <= DIV_W'(`GDEIO_DIV_RST);
      half[1] <= DIV_W'(`GDEIO_DIV_RST);
      reject  <= 1'b0;
      stalled <= 1'b0;
    end else begin
      cfg     <= next_cfg;
      half    <= next_half;
      reject  <= next_reject;
      stalled <= next_stalled;
    end
  end

  // ========================================================================
  // capture (index 0) and drive (index 1) clock dividers
  logic [DIV_W-1:0] div_cnt [2];
  logic             div_phase [2];
  logic             div_run [2];
  logic             div_rise [2];
  logic             div_fall [2];
  logic             fifo_in_ready;

  assign div_run[0] = fifo_in_ready; // capture stalls while the FIFO is full
  assign div_run[1] = 1'b1;

  generate
    for (genvar i = 0; i < 2; i++) begin : g_div
      logic [DIV_W-1:0] next_cnt;
      logic             next_phase;
      logic             tick;
      always_comb begin
        tick       = div_cnt[i] + 1'b1 >= half[i];
        next_cnt   = div_cnt[i];
        next_phase = div_phase[i];
        if (div_run[i]) begin
          next_cnt = tick ? '0 : div_cnt[i] + 1'b1;
          if (tick) next_phase = !div_phase[i];
        end
      end
      assign div_rise[i] = div_run[i] && tick && !div_phase[i];
      assign div_fall[i] = div_run[i] && tick && div_phase[i];
      always_ff @(posedge clock) begin
        if (rst) begin
          div_cnt[i]   <= '0;
          div_phase[i] <= 1'b0;
        end else begin
          div_cnt[i]   <= next_cnt;
          div_phase[i] <= next_phase;
        end
      end
    end
  endgenerate

  assign cap_block = !fifo_in_ready && cfg[`GDEIO_CFG_IN_REG];

  // ========================================================================
  // input capture path
  logic       rise_smp;
  logic       next_rise_smp;
  logic       fall_smp;
  logic       next_fall_smp;
  logic       push;
  logic [1:0] push_word;
  logic       cap_edge;

  assign cap_edge = cfg[`GDEIO_CFG_IN_FALL] ? div_fall[0] : div_rise[0];

  always_comb begin
    next_rise_smp = rise_smp;
    next_fall_smp = fall_smp;
    push          = 1'b0;
    push_word     = {fall_smp, rise_smp};
    if (cfg[`GDEIO_CFG_IN_REG]) begin
      if (cfg[`GDEIO_CFG_IN_DUAL]) begin
        if (div_rise[0]) begin
          next_rise_smp = pad_in;
          push          = 1'b1;
          push_word     = {fall_smp, pad_in};
        end
        if (div_fall[0]) begin
          next_fall_smp = pad_in;
          if (!cfg[`GDEIO_CFG_IN_RESYNC]) begin
            push      = 1'b1;
            push_word = {pad_in, rise_smp};
          end
        end
      end else if (cap_edge) begin
        next_rise_smp = pad_in;
        push          = 1'b1;
        push_word     = {1'b0, pad_in};
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      rise_smp <= 1'b0;
      fall_smp <= 1'b0;
    end else begin
      rise_smp <= next_rise_smp;
      fall_smp <= next_fall_smp;
    end
  end

  // ========================================================================
  // receive buffer and core-side output stage
  logic       fifo_out_valid;
  logic       fifo_out_ready;
  logic [1:0] fifo_out_data;
  logic       rx_valid;
  logic       next_rx_valid;
  logic [1:0] rx_bits;
  logic [1:0] next_rx_bits;

  gdeio_fifo #(
    .WIDTH (2),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clock     (clock),
    .rst       (rst),
    .in_valid  (push),
    .in_ready  (fifo_in_ready),
    .in_data   (push_word),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_out_ready),
    .out_data  (fifo_out_data)
  );

  assign fifo_out_ready     = !rx_valid || core_receive_ready;
  assign core_receive_valid = rx_valid;
  assign core_receive_bits  = rx_bits;

  always_comb begin
    next_rx_valid = rx_valid;
    next_rx_bits  = rx_bits;
    if (fifo_out_ready) begin
      next_rx_valid = fifo_out_valid;
      if (fifo_out_valid) next_rx_bits = fifo_out_data;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      rx_valid <= 1'b0;
      rx_bits  <= 2'h0;
    end else begin
      rx_valid <= next_rx_valid;
      rx_bits  <= next_rx_bits;
    end
  end

  // ========================================================================
  // output and enable path
  logic       obit0;
  logic       next_obit0;
  logic       obit1;
  logic       next_obit1;
  logic       opend;
  logic       next_opend;
  logic       oe_q;
  logic       next_oe_q;
  logic       inv;
  logic       drv_edge;
  logic       oe_edge;

  assign inv      = cfg[`GDEIO_CFG_OUT_INV];
  assign drv_edge = cfg[`GDEIO_CFG_OUT_FALL] ? div_fall[1] : div_rise[1];
  assign oe_edge  = cfg[`GDEIO_CFG_OE_FALL] ? div_fall[1] : div_rise[1];

  always_comb begin
    next_obit0 = obit0;
    next_obit1 = obit1;
    next_opend = opend;
    next_oe_q  = oe_q;
    if (cfg[`GDEIO_CFG_OUT_DUAL]) begin
      if (div_rise[1]) begin
        next_obit0 = pad_drive_bits[0] ^ inv;
        next_opend = pad_drive_bits[1] ^ inv;
      end
      if (div_fall[1]) begin
        next_obit1 = cfg[`GDEIO_CFG_OUT_RESYNC] ? opend
                                                : pad_drive_bits[1] ^ inv;
      end
    end else if (cfg[`GDEIO_CFG_OUT_REG] && drv_edge) begin
      next_obit0 = pad_drive_bits[0] ^ inv;
    end
    if (cfg[`GDEIO_CFG_OE_REG] && oe_edge) begin
      next_oe_q = pad_drive_enable;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      obit0 <= 1'b0;
      obit1 <= 1'b0;
      opend <= 1'b0;
      oe_q  <= 1'b0;
    end else begin
      obit0 <= next_obit0;
      obit1 <= next_obit1;
      opend <= next_opend;
      oe_q  <= next_oe_q;
    end
  end

  // rising half of the drive clock sends bit 0, falling half bit 1
  always_comb begin
    if (cfg[`GDEIO_CFG_OUT_DUAL]) begin
      pad_out = div_phase[1] ? obit0 : obit1;
    end else if (cfg[`GDEIO_CFG_OUT_REG]) begin
      pad_out = obit0;
    end else begin
      pad_out = pad_drive_bits[0];
    end
  end

  assign pad_oe = cfg[`GDEIO_CFG_OE_REG] ? oe_q : pad_drive_enable;

  // ========================================================================
  // bypass routes
  logic [1:0] route;

  assign route       = cfg[`GDEIO_CFG_ROUTE_HI:`GDEIO_CFG_ROUTE_LO];
  assign bypass_path = !cfg[`GDEIO_CFG_IN_REG] && pad_in;
  assign global_clock_net            = bypass_path && route == 2'h0;
  assign global_control_net          = bypass_path && route == 2'h1;
  assign synth_reference_input       = bypass_path && route == 2'h2;
  assign camera_link_reference_input = bypass_path && route == 2'h3;

  // ========================================================================
  // status word
  always_comb begin
    status_word                   = 32'h0;
    status_word[`GDEIO_ST_RX_HI:`GDEIO_ST_RX_LO] = {fall_smp, rise_smp};
    status_word[`GDEIO_ST_PAD]    = pad_in;
    status_word[`GDEIO_ST_REJECT] = reject;
    status_word[`GDEIO_ST_STALL]  = stalled;
    status_word[`GDEIO_ST_OE]     = pad_oe;
  end

endmodule // gdeio_top

/* File: gdeio_regs.svh */
// Purpose: register map, field positions and reset values of the pad cell
// Assumes: 32-bit AXI4-Lite data, one aligned word per register
// Notes:   included by the top module and the bench
`ifndef GDEIO_REGS_SVH
`define GDEIO_REGS_SVH

// ==========================================================================
// register byte offsets
`define GDEIO_CFG_ADDR     4'h0
`define GDEIO_CAPDIV_ADDR  4'h4
`define GDEIO_DRVDIV_ADDR  4'h8
`define GDEIO_STATUS_ADDR  4'hC

// ==========================================================================
// configuration fields
`define GDEIO_CFG_IN_REG      0
`define GDEIO_CFG_IN_FALL     1
`define GDEIO_CFG_OUT_REG     2
`define GDEIO_CFG_OUT_FALL    3
`define GDEIO_CFG_OUT_INV     4
`define GDEIO_CFG_OE_REG      5
`define GDEIO_CFG_OE_FALL     6
`define GDEIO_CFG_IN_DUAL     7
`define GDEIO_CFG_OUT_DUAL    8
`define GDEIO_CFG_IN_RESYNC   9
`define GDEIO_CFG_OUT_RESYNC  10
`define GDEIO_CFG_ROUTE_LO    11
`define GDEIO_CFG_ROUTE_HI    12
`define GDEIO_CFG_W           13
`define GDEIO_CFG_RST         13'h0000

// ==========================================================================
// status fields
`define GDEIO_ST_RX_LO     0
`define GDEIO_ST_RX_HI     1
`define GDEIO_ST_PAD       2
`define GDEIO_ST_REJECT    3
`define GDEIO_ST_STALL     4
`define GDEIO_ST_OE        5

// ==========================================================================
// divider half period, in clock cycles
`define GDEIO_DIV_RST      16'h0001

// ==========================================================================
// AXI responses
`define GDEIO_RESP_OKAY    2'h0
`define GDEIO_RESP_SLVERR  2'h2

`endif

/* File: gdeio_pkg.sv */
// Purpose: shared types of the pad cell
// Assumes: nothing
// Notes:   offsets and fields live in gdeio_regs.svh
package gdeio_pkg;

  // ========================================================================
  // bus slave states
  typedef enum logic {
    GDEIO_WS_COLLECT,
    GDEIO_WS_RESP
  } gdeio_wr_state_t;

  typedef enum logic {
    GDEIO_RS_IDLE,
    GDEIO_RS_DATA
  } gdeio_rd_state_t;

endpackage

/* File: gdeio_fifo.sv */
// Purpose: flip-flop FIFO with valid/ready on both sides
// Assumes: single clock, synchronous active-high reset
// Notes:   depth must be a power of two
`timescale 1ns/1ps
module gdeio_fifo #(
  parameter int WIDTH = 2,
  parameter int DEPTH = 32
) (
  // clock and reset
  input  wire logic             clock,
  input  wire logic             rst,
  // fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);

  localparam int AW = $clog2(DEPTH);

  // ========================================================================
  // parameter check
  generate
    if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_bad
      $error("gdeio_fifo: DEPTH must be a power of two >= 2");
    end
  endgenerate

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_ptr;
  logic [AW:0]      rd_ptr;
  logic [AW:0]      next_wr_ptr;
  logic [AW:0]      next_rd_ptr;
  logic             push;
  logic             pop;

  assign in_ready  = (wr_ptr - rd_ptr) != (AW+1)'(DEPTH);
  assign out_valid = wr_ptr != rd_ptr;
  assign out_data  = mem[rd_ptr[AW-1:0]];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // ========================================================================
  // pointers
  always_comb begin
    next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
    next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
    end
  end

  always_ff @(posedge clock) begin
    if (push) begin
      mem[wr_ptr[AW-1:0]] <= in_data;
    end
  end

endmodule // gdeio_fifo

/* File: gdeio_top_properties.sv */
// Purpose: port checker of the pad cell
// Assumes: one clock, rst synchronous active high
// Notes:   bound into gdeio_top below
`timescale 1ns/1ps
module gdeio_checker (
  // clock and reset
  input wire logic       clock,
  input wire logic       rst,
  // register bus
  input wire logic       s_axi_awvalid,
  input wire logic       s_axi_awready,
  input wire logic       s_axi_wvalid,
  input wire logic       s_axi_wready,
  input wire logic       s_axi_bvalid,
  input wire logic       s_axi_bready,
  input wire logic       s_axi_arvalid,
  input wire logic       s_axi_arready,
  input wire logic       s_axi_rvalid,
  input wire logic       s_axi_rready,
  // stream and pad
  input wire logic [1:0] core_receive_bits,
  input wire logic       core_receive_valid,
  input wire logic       core_receive_ready,
  input wire logic       bypass_path,
  input wire logic       global_clock_net,
  input wire logic       pad_in
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  // ====================
  // handshakes, receive hold, bypass routes and reset
  chk_write_resp: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##2 s_axi_bvalid) else $error("write response late");
  chk_bresp_hold: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");
  chk_read_next: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  chk_ar_blocked: assert property (
    s_axi_rvalid |-> !s_axi_arready) else $error("read overlap");
  chk_rx_hold: assert property (
    core_receive_valid && !core_receive_ready
    |=> core_receive_valid && $stable(core_receive_bits))
    else $error("receive word changed");
  chk_bypass_src: assert property (
    bypass_path |-> pad_in) else $error("bypass not pad level");
  chk_global_clock_net_route: assert property (
    global_clock_net |-> bypass_path) else $error("route without bypass");
  chk_reset_idle: assert property (
    $fell(rst) |-> !s_axi_bvalid && !s_axi_rvalid && !core_receive_valid)
    else $error("busy after reset");
endmodule // gdeio_checker

bind gdeio_top gdeio_checker gdeio_checker_i (.*);

/* File: gdeio_core_model.sv */
// Purpose: core fabric and outside pad seen from the pad cell
// Assumes: pad has a weak pull-up
// Notes:   core takes words unless stalled
`timescale 1ns/1ps
module gdeio_core_model (
  // pad wire
  input  wire logic pad_out,
  input  wire logic pad_oe,
  input  wire logic ext_drive,
  input  wire logic ext_level,
  output logic      pad_in,
  // receive stream
  input  wire logic stall,
  output logic      core_receive_ready
);
  // cell drives first, else outside driver, else pull-up
  assign pad_in = pad_oe ? pad_out : (ext_drive ? ext_level : 1'h1);
  assign core_receive_ready = !stall;
endmodule // gdeio_core_model

/* File: gpio_dual_edge_io_logic_bench.sv */
// Purpose: self-checking bench of the pad cell
// Assumes: capture and drive dividers at half period 1
// Notes:   ordinary cases in rows, awkward cases after
`timescale 1ns/1ps
`include "gdeio_regs.svh"
module gpio_dual_edge_io_logic_bench;
  typedef struct packed {
    logic [15:0] cfg;
    logic [2:0]  pins;
    logic [6:0]  exp;
  } gdeio_row_t;
  logic        clock = 1'h0;
  logic        rst = 1'h1;
  logic [3:0]  s_axi_awaddr = 4'h0;
  logic [3:0]  s_axi_araddr = 4'h0;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic [31:0] s_axi_wdata = 32'h0;
  logic        s_axi_awvalid = 1'h0;
  logic        s_axi_wvalid = 1'h0;
  logic        s_axi_bready = 1'h0;
  logic        s_axi_arvalid = 1'h0;
  logic        s_axi_rready = 1'h0;
  logic [1:0]  pad_drive_bits = 2'h0;
  logic        pad_drive_enable = 1'h0;
  logic        ext_drive = 1'h1;
  logic        ext_level = 1'h1;
  logic        stall = 1'h0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic        s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, core_receive_bits;
  logic [31:0] s_axi_rdata;
  logic        core_receive_valid, core_receive_ready, pad_in;
  logic        bypass_path, global_clock_net, global_control_net;
  logic        synth_reference_input, camera_link_reference_input;
  logic        pad_out, pad_oe, seen0, seen1;
  wire  [6:0]  pins = {bypass_path, global_clock_net, global_control_net,
    synth_reference_input, camera_link_reference_input, pad_out, pad_oe};
  int          error_cnt = 0;
  int          check_count = 0;
  int          cycles = 0;
  int          n;
  gdeio_row_t  rows [6] = '{'{16'h0000, 3'h1, 7'h60},
    '{16'h0800, 3'h5, 7'h52}, '{16'h1000, 3'h6, 7'h4B},
    '{16'h1800, 3'h3, 7'h01}, '{16'h1801, 3'h1, 7'h00},
    '{16'h1800, 3'h1, 7'h44}};
  logic [15:0] mcfg [3] = '{16'h0001, 16'h0081, 16'h0281};
  logic [1:0]  mexp [3] = '{2'h1, 2'h3, 2'h3};

  gdeio_top gdeio_top_i (.*);
  gdeio_core_model gdeio_core_model_i (.*);

  always #2 clock = ~clock;
  // ====================
  // tasks
  task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(logic [3:0] a, logic [31:0] d, logic [1:0] r);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    fork
      begin
        do @(posedge clock); while (!s_axi_awready);
        s_axi_awvalid <= 1'h0;
      end
      begin
        do @(posedge clock); while (!s_axi_wready);
        s_axi_wvalid <= 1'h0;
      end
    join
    s_axi_bready <= 1'h1;
    do @(posedge clock); while (!s_axi_bvalid);
    s_axi_bready <= 1'h0;
    check("bresp", 32'(s_axi_bresp), 32'(r));
  endtask
  task automatic rc(logic [3:0] a, logic [31:0] m, logic [31:0] e,
                    logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    do @(posedge clock); while (!s_axi_arready);
    s_axi_arvalid <= 1'h0;
    s_axi_rready <= 1'h1;
    do @(posedge clock); while (!s_axi_rvalid);
    s_axi_rready <= 1'h0;
    check("rdata", s_axi_rdata & m, e);
    check("rresp", 32'(s_axi_rresp), 32'(r));
  endtask
  task automatic stop_test;
    if (error_cnt == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      error_cnt++;
      stop_test();
    end
  end
  // ====================
  // sequence
  initial begin
    repeat (3) @(posedge clock);
    rst <= 1'h0;
    foreach (rows[i]) begin
      wr(`GDEIO_CFG_ADDR, 32'(rows[i].cfg), `GDEIO_RESP_OKAY);
      {pad_drive_bits[0], pad_drive_enable, ext_level} <= rows[i].pins;
      @(posedge clock);
      check("pins", 32'(pins), 32'(rows[i].exp));
    end
    rst <= 1'h1;
    repeat (3) @(posedge clock);
    rst <= 1'h0;
    rc(`GDEIO_CFG_ADDR, 32'hFFFF, 32'h0, `GDEIO_RESP_OKAY);
    rc(`GDEIO_CAPDIV_ADDR, 32'hFFFF, 32'h1, `GDEIO_RESP_OKAY);
    rc(`GDEIO_DRVDIV_ADDR, 32'hFFFF, 32'h1, `GDEIO_RESP_OKAY);
    rc(4'h1, 32'hFFFFFFFF, 32'h0, `GDEIO_RESP_SLVERR);
    wr(4'h1, 32'h0, `GDEIO_RESP_SLVERR);
    wr(`GDEIO_CFG_ADDR, 32'h0081, `GDEIO_RESP_OKAY);
    repeat (4) @(posedge clock);
    stall <= 1'h1;
    repeat (200) @(posedge clock);
    rc(`GDEIO_STATUS_ADDR, 32'h17, 32'h17, `GDEIO_RESP_OKAY);
    wr(`GDEIO_CFG_ADDR, 32'h0, `GDEIO_RESP_OKAY);
    stall <= 1'h0;
    n = 0;
    repeat (80) begin
      @(posedge clock);
      if (core_receive_valid) begin
        n++;
        check("word", 32'(core_receive_bits), 32'h3);
      end
    end
    check("drained", 32'(n >= 32), 32'h1);
    check("empty", 32'(core_receive_valid), 32'h0);
    wr(`GDEIO_STATUS_ADDR, 32'h10, `GDEIO_RESP_OKAY);
    rc(`GDEIO_STATUS_ADDR, 32'h10, 32'h0, `GDEIO_RESP_OKAY);
    foreach (mcfg[i]) begin
      wr(`GDEIO_CFG_ADDR, 32'(mcfg[i]), `GDEIO_RESP_OKAY);
      repeat (20) @(posedge clock);
      for (n = 0; n < 10 && core_receive_valid !== 1'h1; n++) begin
        @(posedge clock);
      end
      check("mode", 32'(core_receive_bits), 32'(mexp[i]));
    end
    pad_drive_enable <= 1'h1;
    wr(`GDEIO_CFG_ADDR, 32'h0034, `GDEIO_RESP_OKAY);
    repeat (8) @(posedge clock);
    check("inverted", {pad_out, pad_oe}, 32'h3);
    pad_drive_bits <= 2'h1;
    wr(`GDEIO_CFG_ADDR, 32'h0104, `GDEIO_RESP_OKAY);
    seen0 = 1'h0;
    seen1 = 1'h0;
    repeat (6) begin
      @(posedge clock);
      seen0 = seen0 | (pad_out === 1'h0);
      seen1 = seen1 | (pad_out === 1'h1);
    end
    check("dual out", {seen1, seen0}, 32'h3);
    stop_test();
  end
endmodule // gpio_dual_edge_io_logic_bench
